// file: src/ldr_regs.sv
`default_nettype none
module ldr_regs
  import ldr_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  rst,
  // Host register access
  input  wire ldr_host_req_t         hostReq,
  output logic [DATA_W-1:0]          rdData,
  output logic                       rdValid,
  // Converter results
  input  wire ldr_adc_in_t           adcIn,
  // Dimming generator
  input  wire logic [2:0]            dimClockDivider,
  output logic [NUM_CH-1:0]          dimOut,
  output logic [DIM_W-1:0]           chOneDimWidth,
  output logic [DIM_W-1:0]           chTwoDimWidth,
  // Switching on-time
  output logic [ONTIME_W-1:0]        chOneOnTimeWord,
  output logic [ONTIME_W-1:0]        chTwoOnTimeWord
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers

  logic [DATA_W-1:0]   widthLo_q [NUM_CH];
  logic [DATA_W-1:0]   widthLo_d [NUM_CH];
  logic [HI_W-1:0]     widthHi_q [NUM_CH];
  logic [HI_W-1:0]     widthHi_d [NUM_CH];
  logic [ONTIME_W-1:0] onTime_q  [NUM_CH];
  logic [ONTIME_W-1:0] onTime_d  [NUM_CH];
  logic [DIM_W-1:0]    width     [NUM_CH];

  function automatic logic wrHit(input ldr_host_req_t r, input logic [ADDR_W-1:0] a);
    wrHit = r.wrEn && (r.addr == a);
  endfunction

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      widthLo_d[c] = widthLo_q[c];
      widthHi_d[c] = widthHi_q[c];
      onTime_d[c]  = onTime_q[c];
    end
    if (wrHit(hostReq, ADDR_CH1_WIDTH_LO)) begin
      widthLo_d[0] = hostReq.wrData;
    end
    if (wrHit(hostReq, ADDR_CH1_WIDTH_HI)) begin
      widthHi_d[0] = hostReq.wrData[HI_W-1:0];
    end
    if (wrHit(hostReq, ADDR_CH2_WIDTH_LO)) begin
      widthLo_d[1] = hostReq.wrData;
    end
    if (wrHit(hostReq, ADDR_CH2_WIDTH_HI)) begin
      widthHi_d[1] = hostReq.wrData[HI_W-1:0];
    end
    if (wrHit(hostReq, ADDR_CH1_ON_TIME)) begin
      onTime_d[0] = hostReq.wrData[ONTIME_W-1:0];
    end
    if (wrHit(hostReq, ADDR_CH2_ON_TIME)) begin
      onTime_d[1] = hostReq.wrData[ONTIME_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int c = 0; c < NUM_CH; c++) begin
        widthLo_q[c] <= RST_WIDTH_LO;
        widthHi_q[c] <= RST_WIDTH_HI;
        onTime_q[c]  <= RST_ON_TIME;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        widthLo_q[c] <= widthLo_d[c];
        widthHi_q[c] <= widthHi_d[c];
        onTime_q[c]  <= onTime_d[c];
      end
    end
  end

  assign chOneDimWidth   = width[0];
  assign chTwoDimWidth   = width[1];
  assign chOneOnTimeWord = onTime_q[0];
  assign chTwoOnTimeWord = onTime_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Dimming generator

  logic [PRE_W-1:0] preCnt_q;
  logic [PRE_W-1:0] preCnt_d;
  logic             dimTick;
  logic [DIM_W-1:0] dimCnt_q [NUM_CH];
  logic [DIM_W-1:0] dimCnt_d [NUM_CH];
  logic [NUM_CH-1:0] dimOut_q;
  logic [NUM_CH-1:0] dimOut_d;

  always_comb begin
    dimTick  = (preCnt_q >= dimDivRatio(dimClockDivider) - 7'h01);
    preCnt_d = dimTick ? 7'h00 : preCnt_q + 7'h01;
  end

  generate
    for (genvar g = 0; g < NUM_CH; g++) begin : gDim
      assign width[g] = {widthHi_q[g], widthLo_q[g]};
      always_comb begin
        dimCnt_d[g] = dimTick ? dimCnt_q[g] + 10'h001 : dimCnt_q[g];
        dimOut_d[g] = (dimCnt_d[g] < width[g]);
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      preCnt_q <= 7'h00;
      dimOut_q <= 2'h0;
      for (int c = 0; c < NUM_CH; c++) begin
        dimCnt_q[c] <= 10'h000;
      end
    end else begin
      preCnt_q <= preCnt_d;
      dimOut_q <= dimOut_d;
      for (int c = 0; c < NUM_CH; c++) begin
        dimCnt_q[c] <= dimCnt_d[c];
      end
    end
  end

  assign dimOut = dimOut_q;

  ////////////////////////////////////////////////////////////////////////////
  // Measurement registers

  logic [DATA_W-1:0] vin_q    [NUM_CH];
  logic [DATA_W-1:0] vin_d    [NUM_CH];
  logic [DATA_W-1:0] led_q    [NUM_CH];
  logic [DATA_W-1:0] led_d    [NUM_CH];
  logic [DATA_W-1:0] ledOn_q  [NUM_CH];
  logic [DATA_W-1:0] ledOn_d  [NUM_CH];
  logic [DATA_W-1:0] ledOff_q [NUM_CH];
  logic [DATA_W-1:0] ledOff_d [NUM_CH];
  logic [ADC_W-1:0]  temp_q;
  logic [ADC_W-1:0]  temp_d;
  logic [DATA_W-1:0] bias_q;
  logic [DATA_W-1:0] bias_d;
  logic [DATA_W-1:0] adcTop;

  // Conversion results load these, and dimming output edges copy the LED code into the on/off samples; host writes never reach them
  always_comb begin
    adcTop = adcIn.result[ADC_W-1:ADC_W-DATA_W];
    temp_d = temp_q;
    bias_d = bias_q;
    for (int c = 0; c < NUM_CH; c++) begin
      vin_d[c]    = vin_q[c];
      led_d[c]    = led_q[c];
      ledOn_d[c]  = ledOn_q[c];
      ledOff_d[c] = ledOff_q[c];
      if (dimOut_q[c] && !dimOut_d[c]) begin
        ledOn_d[c] = led_q[c];
      end
      if (!dimOut_q[c] && dimOut_d[c]) begin
        ledOff_d[c] = led_q[c];
      end
    end
    if (adcIn.valid) begin
      case (adcIn.src)
        ADC_SRC_CH1_VIN:  vin_d[0] = adcTop;
        ADC_SRC_CH1_VLED: led_d[0] = adcTop;
        ADC_SRC_CH2_VIN:  vin_d[1] = adcTop;
        ADC_SRC_CH2_VLED: led_d[1] = adcTop;
        ADC_SRC_TEMP:     temp_d   = adcIn.result;
        ADC_SRC_BIAS:     bias_d   = adcTop;
        default:          temp_d   = temp_q;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      temp_q <= RST_TEMP;
      bias_q <= RST_MEAS;
      for (int c = 0; c < NUM_CH; c++) begin
        vin_q[c]    <= RST_MEAS;
        led_q[c]    <= RST_MEAS;
        ledOn_q[c]  <= RST_MEAS;
        ledOff_q[c] <= RST_MEAS;
      end
    end else begin
      temp_q <= temp_d;
      bias_q <= bias_d;
      for (int c = 0; c < NUM_CH; c++) begin
        vin_q[c]    <= vin_d[c];
        led_q[c]    <= led_d[c];
        ledOn_q[c]  <= ledOn_d[c];
        ledOff_q[c] <= ledOff_d[c];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [DATA_W-1:0] rdData_q;
  logic [DATA_W-1:0] rdData_d;
  logic              rdValid_q;

  always_comb begin
    rdData_d = rdData_q;
    if (hostReq.rdEn) begin
      case (hostReq.addr)
        ADDR_CH1_WIDTH_LO: rdData_d = widthLo_q[0];
        ADDR_CH1_WIDTH_HI: rdData_d = {6'h00, widthHi_q[0]};
        ADDR_CH2_WIDTH_LO: rdData_d = widthLo_q[1];
        ADDR_CH2_WIDTH_HI: rdData_d = {6'h00, widthHi_q[1]};
        ADDR_CH1_ON_TIME:  rdData_d = {2'h0, onTime_q[0]};
        ADDR_CH2_ON_TIME:  rdData_d = {2'h0, onTime_q[1]};
        ADDR_CH1_VIN:      rdData_d = vin_q[0];
        ADDR_CH1_VLED:     rdData_d = led_q[0];
        ADDR_CH1_VLED_ON:  rdData_d = ledOn_q[0];
        ADDR_CH1_VLED_OFF: rdData_d = ledOff_q[0];
        ADDR_CH2_VIN:      rdData_d = vin_q[1];
        ADDR_CH2_VLED:     rdData_d = led_q[1];
        ADDR_CH2_VLED_ON:  rdData_d = ledOn_q[1];
        ADDR_CH2_VLED_OFF: rdData_d = ledOff_q[1];
        ADDR_TEMP_LO:      rdData_d = {6'h00, temp_q[1:0]};
        ADDR_TEMP_HI:      rdData_d = temp_q[ADC_W-1:2];
        ADDR_BIAS:         rdData_d = bias_q;
        default:           rdData_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdData_q  <= 8'h00;
      rdValid_q <= 1'b0;
    end else begin
      rdData_q  <= rdData_d;
      rdValid_q <= hostReq.rdEn;
    end
  end

  assign rdData  = rdData_q;
  assign rdValid = rdValid_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  property p_ch1WidthLoWrite;
    wrHit(hostReq, ADDR_CH1_WIDTH_LO) |=> chOneDimWidth[7:0] == $past(hostReq.wrData);
  endproperty
  a_ch1WidthLoWrite: assert property (p_ch1WidthLoWrite) else $error("ch1 width low");

  property p_ch2WidthHiWrite;
    wrHit(hostReq, ADDR_CH2_WIDTH_HI) |=> chTwoDimWidth[9:8] == $past(hostReq.wrData[1:0]);
  endproperty
  a_ch2WidthHiWrite: assert property (p_ch2WidthHiWrite) else $error("ch2 width high");

  property p_ch1OnTimeWrite;
    wrHit(hostReq, ADDR_CH1_ON_TIME) |=> chOneOnTimeWord == $past(hostReq.wrData[5:0]);
  endproperty
  a_ch1OnTimeWrite: assert property (p_ch1OnTimeWrite) else $error("ch1 on-time");

  property p_ch2OnTimeRead;
    hostReq.rdEn && hostReq.addr == ADDR_CH2_ON_TIME && !hostReq.wrEn
      |=> rdValid && rdData == {2'h0, chTwoOnTimeWord};
  endproperty
  a_ch2OnTimeRead: assert property (p_ch2OnTimeRead) else $error("ch2 on-time read");

  property p_vinCapture;
    adcIn.valid && adcIn.src == ADC_SRC_CH1_VIN |=> vin_q[0] == $past(adcIn.result[9:2]);
  endproperty
  a_vinCapture: assert property (p_vinCapture) else $error("ch1 input capture");

  property p_biasReadOnly;
    hostReq.wrEn && hostReq.addr == ADDR_BIAS && !adcIn.valid |=> $stable(bias_q);
  endproperty
  a_biasReadOnly: assert property (p_biasReadOnly) else $error("bias written");

  property p_ledOnSample;
    $fell(dimOut[0]) |-> ledOn_q[0] == $past(led_q[0]);
  endproperty
  a_ledOnSample: assert property (p_ledOnSample) else $error("led-on sample");

  property p_dimTickSpacing;
    $changed(dimCnt_q[0]) |=> !$changed(dimCnt_q[0]) [*6];
  endproperty
  a_dimTickSpacing: assert property (p_dimTickSpacing) else $error("dim tick too fast");

  property p_reservedZero;
    hostReq.rdEn && hostReq.addr == ADDR_CH1_WIDTH_HI |=> rdData[7:2] == 6'h00;
  endproperty
  a_reservedZero: assert property (p_reservedZero) else $error("reserved bits set");

endmodule
`default_nettype wire

// file: src/ldr_pkg.sv
`default_nettype none
package ldr_pkg;

  // Widths
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 8;
  localparam int DIM_W    = 10;
  localparam int HI_W     = 2;
  localparam int ONTIME_W = 6;
  localparam int ADC_W    = 10;
  localparam int PRE_W    = 7;
  localparam int NUM_CH   = 2;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CH1_WIDTH_LO = 6'h0D;
  localparam logic [ADDR_W-1:0] ADDR_CH1_WIDTH_HI = 6'h0E;
  localparam logic [ADDR_W-1:0] ADDR_CH2_WIDTH_LO = 6'h0F;
  localparam logic [ADDR_W-1:0] ADDR_CH2_WIDTH_HI = 6'h10;
  localparam logic [ADDR_W-1:0] ADDR_CH1_ON_TIME  = 6'h11;
  localparam logic [ADDR_W-1:0] ADDR_CH2_ON_TIME  = 6'h12;
  localparam logic [ADDR_W-1:0] ADDR_CH1_VIN      = 6'h13;
  localparam logic [ADDR_W-1:0] ADDR_CH1_VLED     = 6'h14;
  localparam logic [ADDR_W-1:0] ADDR_CH1_VLED_ON  = 6'h15;
  localparam logic [ADDR_W-1:0] ADDR_CH1_VLED_OFF = 6'h16;
  localparam logic [ADDR_W-1:0] ADDR_CH2_VIN      = 6'h17;
  localparam logic [ADDR_W-1:0] ADDR_CH2_VLED     = 6'h18;
  localparam logic [ADDR_W-1:0] ADDR_CH2_VLED_ON  = 6'h19;
  localparam logic [ADDR_W-1:0] ADDR_CH2_VLED_OFF = 6'h1A;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_LO      = 6'h1B;
  localparam logic [ADDR_W-1:0] ADDR_TEMP_HI      = 6'h1C;
  localparam logic [ADDR_W-1:0] ADDR_BIAS         = 6'h1D;

  // Reset values
  localparam logic [DATA_W-1:0]   RST_WIDTH_LO = 8'h00;
  localparam logic [HI_W-1:0]     RST_WIDTH_HI = 2'h0;
  localparam logic [ONTIME_W-1:0] RST_ON_TIME  = 6'h07;
  localparam logic [DATA_W-1:0]   RST_MEAS     = 8'h00;
  localparam logic [ADC_W-1:0]    RST_TEMP     = 10'h000;

  // Conversion source codes on the converter result port
  localparam logic [3:0] ADC_SRC_CH1_VIN  = 4'h0;
  localparam logic [3:0] ADC_SRC_CH1_VLED = 4'h1;
  localparam logic [3:0] ADC_SRC_CH2_VIN  = 4'h2;
  localparam logic [3:0] ADC_SRC_CH2_VLED = 4'h3;
  localparam logic [3:0] ADC_SRC_TEMP     = 4'h4;
  localparam logic [3:0] ADC_SRC_BIAS     = 4'h5;

  // Host access from the serial port decoder
  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
  } ldr_host_req_t;

  // One conversion result
  typedef struct packed {
    logic             valid;
    logic [3:0]       src;
    logic [ADC_W-1:0] result;
  } ldr_adc_in_t;

  // Dimming clock divide ratio for each divider select code
  function automatic logic [PRE_W-1:0] dimDivRatio(input logic [2:0] sel);
    case (sel)
      3'h0:    dimDivRatio = 7'h07;
      3'h1:    dimDivRatio = 7'h08;
      3'h2:    dimDivRatio = 7'h0A;
      3'h3:    dimDivRatio = 7'h0C;
      3'h4:    dimDivRatio = 7'h10;
      3'h5:    dimDivRatio = 7'h18;
      3'h6:    dimDivRatio = 7'h31;
      default: dimDivRatio = 7'h62;
    endcase
  endfunction

endpackage
`default_nettype wire

// file: bench/ldr_host_model.sv
`default_nettype none
module ldr_host_model
  import ldr_pkg::*;
(
  // Clock
  input  wire logic                  clk_sys,
  // Register access
  output ldr_host_req_t              hostReq,
  input  wire logic [DATA_W-1:0]     rdData,
  input  wire logic                  rdValid
);
  timeunit 1ns;
  timeprecision 100ps;

  initial hostReq = '0;

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle write strobe, released at the edge that takes it
  task automatic writeReg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk_sys);
    hostReq <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
    @(posedge clk_sys);
    hostReq.wrEn <= 1'b0;
  endtask

  // One-cycle read strobe; data taken while the valid pulse stands
  task automatic readReg(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                         output logic v);
    @(posedge clk_sys);
    hostReq <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wrData: 8'h00};
    @(posedge clk_sys);
    hostReq.rdEn <= 1'b0;
    @(negedge clk_sys);
    d = rdData;
    v = rdValid;
  endtask
endmodule
`default_nettype wire

// file: bench/ldr_regs_bench.sv
`default_nettype none
module ldr_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import ldr_pkg::*;

  logic                clk_sys = 1'b0;
  logic                rst     = 1'b1;
  ldr_host_req_t       hostReq;
  logic [DATA_W-1:0]   rdData;
  logic                rdValid;
  ldr_adc_in_t         adcIn   = '0;
  logic [2:0]          divSel  = 3'h0;
  logic [NUM_CH-1:0]   dimOut;
  logic [DIM_W-1:0]    chOneDimWidth;
  logic [DIM_W-1:0]    chTwoDimWidth;
  logic [ONTIME_W-1:0] chOneOnTimeWord;
  logic [ONTIME_W-1:0] chTwoOnTimeWord;
  logic [15:0]         run [NUM_CH]      = '{16'h0000, 16'h0000};
  logic [15:0]         lastHigh [NUM_CH] = '{16'h0000, 16'h0000};
  int                  fail_count  = 0;
  int                  check_count = 0;

  always #12.5 clk_sys = ~clk_sys;

  ldr_host_model host (.clk_sys(clk_sys), .hostReq(hostReq), .rdData(rdData),
                       .rdValid(rdValid));

  ldr_regs uut (.clk_sys(clk_sys), .rst(rst), .hostReq(hostReq), .rdData(rdData),
                .rdValid(rdValid), .adcIn(adcIn), .dimClockDivider(divSel),
                .dimOut(dimOut), .chOneDimWidth(chOneDimWidth),
                .chTwoDimWidth(chTwoDimWidth), .chOneOnTimeWord(chOneOnTimeWord),
                .chTwoOnTimeWord(chTwoOnTimeWord));

  ////////////////////////////////////////////////////////////////////////////
  // Length of the last high phase of each dimming output
  always @(posedge clk_sys) begin
    for (int c = 0; c < NUM_CH; c++) begin
      if (dimOut[c] === 1'b1) begin
        run[c] <= run[c] + 16'h0001;
      end else begin
        if (run[c] != 16'h0000) lastHigh[c] <= run[c];
        run[c] <= 16'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic expRead(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    logic              v;
    host.readReg(a, d, v);
    check({15'h0000, v}, 16'h0001, "read valid");
    check({8'h00, d}, {8'h00, exp}, $sformatf("read of %h", a));
  endtask

  task automatic adc(input logic [3:0] s, input logic [ADC_W-1:0] r);
    @(posedge clk_sys);
    adcIn <= '{valid: 1'b1, src: s, result: r};
    @(posedge clk_sys);
    adcIn.valid <= 1'b0;
  endtask

  task automatic waitLvl(input int c, input logic lvl);
    int n;
    n = 0;
    while (dimOut[c] !== lvl && n < 20000) begin
      @(negedge clk_sys);
      n++;
    end
    check({15'h0000, dimOut[c]}, {15'h0000, lvl}, "dim output level");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(60000 * 25);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    // Reset values of the whole map
    for (int a = 'h0D; a <= 'h1D; a++) begin
      expRead(a[ADDR_W-1:0], (a == 'h11 || a == 'h12) ? 8'h07 : 8'h00);
    end
    $display("test reset done");
    // Width and on-time writes, reserved bits masked
    host.writeReg(ADDR_CH1_WIDTH_LO, 8'h5A);
    host.writeReg(ADDR_CH1_WIDTH_HI, 8'hFF);
    host.writeReg(ADDR_CH2_WIDTH_LO, 8'hA5);
    host.writeReg(ADDR_CH2_WIDTH_HI, 8'hFE);
    host.writeReg(ADDR_CH1_ON_TIME, 8'hFF);
    host.writeReg(ADDR_CH2_ON_TIME, 8'hEA);
    host.writeReg(6'h3F, 8'hFF);
    expRead(ADDR_CH1_WIDTH_LO, 8'h5A);
    expRead(ADDR_CH1_WIDTH_HI, 8'h03);
    expRead(ADDR_CH2_WIDTH_LO, 8'hA5);
    expRead(ADDR_CH2_WIDTH_HI, 8'h02);
    expRead(ADDR_CH1_ON_TIME, 8'h3F);
    expRead(ADDR_CH2_ON_TIME, 8'h2A);
    expRead(6'h3F, 8'h00);
    expRead(6'h0C, 8'h00);
    check({6'h00, chOneDimWidth}, 16'h035A, "width one");
    check({6'h00, chTwoDimWidth}, 16'h02A5, "width two");
    check({10'h000, chOneOnTimeWord}, 16'h003F, "on-time one");
    check({10'h000, chTwoOnTimeWord}, 16'h002A, "on-time two");
    $display("test control registers done");
    // Conversion results, one register each
    adc(ADC_SRC_CH1_VIN, 10'h3FF);
    adc(ADC_SRC_CH1_VLED, 10'h3FC);
    adc(ADC_SRC_CH2_VIN, 10'h155);
    adc(ADC_SRC_CH2_VLED, 10'h0AB);
    adc(ADC_SRC_TEMP, 10'h2D7);
    adc(ADC_SRC_BIAS, 10'h201);
    adc(4'h6, 10'h3FF);
    host.writeReg(ADDR_CH1_VIN, 8'h00);
    host.writeReg(ADDR_BIAS, 8'h11);
    expRead(ADDR_CH1_VIN, 8'hFF);
    expRead(ADDR_CH1_VLED, 8'hFF);
    expRead(ADDR_CH2_VIN, 8'h55);
    expRead(ADDR_CH2_VLED, 8'h2A);
    expRead(ADDR_TEMP_LO, 8'h03);
    expRead(ADDR_TEMP_HI, 8'hB5);
    expRead(ADDR_BIAS, 8'h80);
    expRead(ADDR_CH1_VLED_ON, 8'h00);
    $display("test measurements done");
    // Dimming duty for two divider settings
    host.writeReg(ADDR_CH1_WIDTH_LO, 8'h02);
    host.writeReg(ADDR_CH1_WIDTH_HI, 8'h01);
    host.writeReg(ADDR_CH2_WIDTH_LO, 8'h01);
    host.writeReg(ADDR_CH2_WIDTH_HI, 8'h03);
    for (int s = 0; s < 2; s++) begin
      @(posedge clk_sys);
      divSel <= s[2:0];
      repeat (2) begin
        waitLvl(0, 1'b1);
        waitLvl(0, 1'b0);
      end
      waitLvl(1, 1'b0);
      // High phase length is latched one edge after the fall
      @(negedge clk_sys);
      check(lastHigh[0], (s == 0) ? 16'h070E : 16'h0810, "high time one");
      check(lastHigh[1], (s == 0) ? 16'h1507 : 16'h1808, "high time two");
    end
    $display("test dimming done");
    // LED code capture at both edges of channel one
    waitLvl(0, 1'b0);
    adc(ADC_SRC_CH1_VLED, 10'h154);
    waitLvl(0, 1'b1);
    adc(ADC_SRC_CH1_VLED, 10'h2A8);
    waitLvl(0, 1'b0);
    expRead(ADDR_CH1_VLED_OFF, 8'h55);
    expRead(ADDR_CH1_VLED_ON, 8'hAA);
    expRead(ADDR_CH1_VLED, 8'hAA);
    expRead(ADDR_CH2_VLED_ON, 8'h2A);
    expRead(ADDR_CH2_VLED_OFF, 8'h2A);
    $display("test edge capture done");
    summarize();
  end
endmodule
`default_nettype wire
